//--- logic/sqf_fault_status.sv
// sequence-order and control fault status registers with write-1-to-clear
// How it works
// - bits clear on written one, pin and thermal bits only once their condition is gone; channel bits and the check byte bit also clear while disabled
// - exit mismatch per channel sets its bit
// - exit check follows rising control, at 0x1e
// - entry check on falling control, at 0x20
// - disabled channel bit stays zero
// - sequence bits sticky, clear always, re-set
// - bit4 register check fault, sticky, re-sets
// - bit3 pin fault while driving low, always
// - pin fault clears only once removed
// - bit2 thermal latch, clears once cool
// - bit1 sync pin fault when enabled
// - sync fault clears only once removed
// - bit0 on bad or missing check byte
// - check fault zero when disabled, re-sets
`timescale 1ns/1ps
`include "sqf_map.svh"

module sqf_fault_status #(
  parameter int NCH = 6,
  parameter int CW = 4
) (
  input wire logic CLK,
  input wire logic NRST,
  // register port from the serial interface, same clock
  input wire logic [7:0] REG_ADDR,
  input wire logic REG_WR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_RD,
  output logic [7:0] REG_RDATA,
  // sleep sequencing
  input wire logic ACTIVE_SLEEP_CONTROL,
  input wire logic SEQ_RECORD_DONE,
  input wire logic [NCH*CW-1:0] SLEEP_EXIT_RECORDED_COUNT,
  input wire logic [NCH*CW-1:0] SLEEP_EXIT_EXPECTED_COUNT,
  input wire logic [NCH*CW-1:0] SLEEP_ENTRY_RECORDED_COUNT,
  input wire logic [NCH*CW-1:0] SLEEP_ENTRY_EXPECTED_COUNT,
  input wire logic [NCH-1:0] SLEEP_EXIT_FAULT_ENABLE,
  input wire logic [NCH-1:0] SLEEP_ENTRY_FAULT_ENABLE,
  // runtime register check
  input wire logic REG_CHECK_ENABLE,
  input wire logic REG_CHECK_DONE,
  input wire logic REG_CHECK_BAD,
  // interrupt output pin supervision
  input wire logic INTERRUPT_OUT_PIN_DRIVE_LOW,
  input wire logic INTERRUPT_OUT_PIN_LEVEL,
  // thermal shutdown
  input wire logic THERMAL_SHUTDOWN_ENABLE,
  input wire logic THERMAL_OVERTEMP,
  // sync pin supervision
  input wire logic SYNC_CHECK_ENABLE,
  input wire logic SYNC_PIN_DRIVE_LOW,
  input wire logic SYNC_PIN_LEVEL,
  // packet error code
  input wire logic PEC_ENABLE,
  input wire logic REQUIRE_PACKET_CHECK,
  input wire logic XFER_DONE,
  input wire logic XFER_IS_WRITE,
  input wire logic XFER_HAD_PEC,
  input wire logic XFER_PEC_BAD,
  output logic FAULT_PENDING // any status bit set
);
  // ==========================================
  // declarations
  logic [1:0] act_sync, irq_sync, sync_sync, hot_sync; // two-stage synchronisers
  logic [1:0] next_act_sync, next_irq_sync, next_sync_sync, next_hot_sync;
  logic act_prev, next_act_prev; // last synchronised control level
  logic [2:0] act_fill, next_act_fill; // edges ignored until the chain is filled
  logic [1:0] irq_drv_dly, sync_drv_dly; // drive requests aligned to pin sample
  logic [1:0] next_irq_drv_dly, next_sync_drv_dly;
  sqf_pkg::sqf_seq_state_t seq_state, next_seq_state; // which sequence is recorded
  logic act_rise, act_fall; // sleep exit and sleep entry started
  logic [NCH-1:0] exit_set, entry_set; // per-channel mismatch events
  logic [NCH-1:0] exit_clr, entry_clr; // per-channel clear terms
  logic [`SQF_CTL_BITS-1:0] ctl_set, ctl_clr; // control fault events and clears
  logic [`SQF_CTL_BITS-1:0] ctl_hold; // live conditions blocking clear
  logic [NCH-1:0] exit_q; // sleep_exit_order_fault_status
  logic [NCH-1:0] entry_q; // sleep_entry_order_fault_status
  logic [`SQF_CTL_BITS-1:0] ctl_q; // control_comm_fault_status
  logic irq_fault_now, sync_fault_now; // pin reads high while pulled low
  logic wr_exit, wr_entry, wr_ctl; // decoded write strobes
  logic [7:0] next_rdata;
  logic next_pending;
  // ==========================================
  // input synchronisers and edge history, next values
  // drive requests are delayed to line up with the two-stage pin sample,
  // otherwise a fresh drive would compare against a stale pin level
  always_comb begin
    next_act_sync = {act_sync[0], ACTIVE_SLEEP_CONTROL};
    next_irq_sync = {irq_sync[0], INTERRUPT_OUT_PIN_LEVEL};
    next_sync_sync = {sync_sync[0], SYNC_PIN_LEVEL};
    next_hot_sync = {hot_sync[0], THERMAL_OVERTEMP};
    next_act_prev = act_sync[1];
    next_irq_drv_dly = {irq_drv_dly[0], INTERRUPT_OUT_PIN_DRIVE_LOW};
    next_sync_drv_dly = {sync_drv_dly[0], SYNC_PIN_DRIVE_LOW};
    next_act_fill = {act_fill[1:0], 1'b1};
  end
  // ==========================================
  // synchroniser registers
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      act_sync <= 2'h0;
      irq_sync <= 2'h0;
      sync_sync <= 2'h0;
      hot_sync <= 2'h0;
      act_prev <= 1'h0;
      irq_drv_dly <= 2'h0;
      sync_drv_dly <= 2'h0;
      act_fill <= 3'h0;
    end else begin
      act_sync <= next_act_sync;
      irq_sync <= next_irq_sync;
      sync_sync <= next_sync_sync;
      hot_sync <= next_hot_sync;
      act_prev <= next_act_prev;
      irq_drv_dly <= next_irq_drv_dly;
      sync_drv_dly <= next_sync_drv_dly;
      act_fill <= next_act_fill;
    end
  end
  // edges and live pin conditions, from second stages only
  // a pin already high at release must not look like a rising edge
  assign act_rise = act_fill[2] & act_sync[1] & ~act_prev;
  assign act_fall = act_fill[2] & ~act_sync[1] & act_prev;
  assign irq_fault_now = irq_drv_dly[1] & irq_sync[1];
  assign sync_fault_now = sync_drv_dly[1] & sync_sync[1];
  // ==========================================
  // sequence tracker, next state
  // a new edge before the recorder finishes restarts the wait, so the
  // latest direction decides which register the result lands in
  always_comb begin
    next_seq_state = seq_state;
    unique case (seq_state)
      sqf_pkg::SQF_IDLE: begin // waiting for a control edge
        if (act_rise) begin
          next_seq_state = sqf_pkg::SQF_EXIT_WAIT;
        end else if (act_fall) begin
          next_seq_state = sqf_pkg::SQF_ENTRY_WAIT;
        end
      end
      sqf_pkg::SQF_EXIT_WAIT: begin // exit recording in progress
        if (act_fall) begin
          next_seq_state = sqf_pkg::SQF_ENTRY_WAIT;
        end else if (SEQ_RECORD_DONE) begin
          next_seq_state = sqf_pkg::SQF_IDLE;
        end
      end
      sqf_pkg::SQF_ENTRY_WAIT: begin // entry recording in progress
        if (act_rise) begin
          next_seq_state = sqf_pkg::SQF_EXIT_WAIT;
        end else if (SEQ_RECORD_DONE) begin
          next_seq_state = sqf_pkg::SQF_IDLE;
        end
      end
      default: begin // unused code falls back to idle
        next_seq_state = sqf_pkg::SQF_IDLE;
      end
    endcase
  end
  // ==========================================
  // sequence tracker register
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      seq_state <= sqf_pkg::SQF_IDLE;
    end else begin
      seq_state <= next_seq_state;
    end
  end
  // ==========================================
  // write decode and set/clear terms
  assign wr_exit = REG_WR & (REG_ADDR == `SQF_SLEEP_EXIT_ORDER_FAULT_STATUS_OFS);
  assign wr_entry = REG_WR & (REG_ADDR == `SQF_SLEEP_ENTRY_ORDER_FAULT_STATUS_OFS);
  assign wr_ctl = REG_WR & (REG_ADDR == `SQF_CONTROL_COMM_FAULT_STATUS_OFS);
  // per-channel compare, only at the end of a recorded sequence
  always_comb begin
    exit_set = '0;
    entry_set = '0;
    for (int i = 0; i < NCH; i++) begin
      exit_set[i] = (seq_state == sqf_pkg::SQF_EXIT_WAIT) & SEQ_RECORD_DONE &
                    SLEEP_EXIT_FAULT_ENABLE[i] &
                    (SLEEP_EXIT_RECORDED_COUNT[i*CW +: CW] !=
                     SLEEP_EXIT_EXPECTED_COUNT[i*CW +: CW]);
      entry_set[i] = (seq_state == sqf_pkg::SQF_ENTRY_WAIT) & SEQ_RECORD_DONE &
                     SLEEP_ENTRY_FAULT_ENABLE[i] &
                     (SLEEP_ENTRY_RECORDED_COUNT[i*CW +: CW] !=
                      SLEEP_ENTRY_EXPECTED_COUNT[i*CW +: CW]);
    end
  end
  assign exit_clr = ({NCH{wr_exit}} & REG_WDATA[NCH-1:0]) | ~SLEEP_EXIT_FAULT_ENABLE;
  assign entry_clr = ({NCH{wr_entry}} & REG_WDATA[NCH-1:0]) | ~SLEEP_ENTRY_FAULT_ENABLE;
  // control fault events and clear blocks
  always_comb begin
    ctl_set = '0;
    ctl_hold = '0;
    ctl_set[`SQF_CTL_PEC_BIT] = PEC_ENABLE & XFER_DONE &
        (XFER_PEC_BAD | (REQUIRE_PACKET_CHECK & XFER_IS_WRITE & ~XFER_HAD_PEC));
    ctl_set[`SQF_CTL_SYNC_PIN_BIT] = SYNC_CHECK_ENABLE & sync_fault_now;
    ctl_set[`SQF_CTL_THERMAL_BIT] = THERMAL_SHUTDOWN_ENABLE & hot_sync[1];
    ctl_set[`SQF_CTL_IRQ_PIN_BIT] = irq_fault_now;
    ctl_set[`SQF_CTL_REG_CHECK_BIT] = REG_CHECK_ENABLE & REG_CHECK_DONE & REG_CHECK_BAD;
    ctl_hold[`SQF_CTL_SYNC_PIN_BIT] = sync_fault_now;
    ctl_hold[`SQF_CTL_THERMAL_BIT] = hot_sync[1];
    ctl_hold[`SQF_CTL_IRQ_PIN_BIT] = irq_fault_now;
  end
  always_comb begin
    ctl_clr = {`SQF_CTL_BITS{wr_ctl}} & REG_WDATA[`SQF_CTL_BITS-1:0];
    ctl_clr[`SQF_CTL_PEC_BIT] = ctl_clr[`SQF_CTL_PEC_BIT] | ~PEC_ENABLE;
  end
  // ==========================================
  // status registers
  // sticky sequence and control bits
  sqf_sticky #(.W(NCH)) u_exit (
    .clk(CLK),
    .nrst(NRST),
    .set(exit_set),
    .clr(exit_clr),
    .hold({NCH{1'b0}}),
    .q(exit_q)
  );
  sqf_sticky #(.W(NCH)) u_entry (
    .clk(CLK),
    .nrst(NRST),
    .set(entry_set),
    .clr(entry_clr),
    .hold({NCH{1'b0}}),
    .q(entry_q)
  );
  sqf_sticky #(.W(`SQF_CTL_BITS)) u_ctl (
    .clk(CLK),
    .nrst(NRST),
    .set(ctl_set),
    .clr(ctl_clr),
    .hold(ctl_hold),
    .q(ctl_q)
  );
  // ==========================================
  // read data and summary, next values
  // read data holds between reads so the serial shifter can take its time
  always_comb begin
    next_rdata = REG_RDATA;
    if (REG_RD) begin
      unique case (REG_ADDR)
        `SQF_SLEEP_EXIT_ORDER_FAULT_STATUS_OFS: begin
          next_rdata = {{(8-NCH){1'b0}}, exit_q};
        end
        `SQF_SLEEP_ENTRY_ORDER_FAULT_STATUS_OFS: begin
          next_rdata = {{(8-NCH){1'b0}}, entry_q};
        end
        `SQF_CONTROL_COMM_FAULT_STATUS_OFS: begin
          next_rdata = {{(8-`SQF_CTL_BITS){1'b0}}, ctl_q};
        end
        // other offsets belong elsewhere, read zero here
        default: begin
          next_rdata = `SQF_RDATA_RESET;
        end
      endcase
    end
    next_pending = (|exit_q) | (|entry_q) | (|ctl_q);
  end
  // ==========================================
  // output registers
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      REG_RDATA <= `SQF_RDATA_RESET;
      FAULT_PENDING <= 1'h0;
    end else begin
      REG_RDATA <= next_rdata;
      FAULT_PENDING <= next_pending;
    end
  end
endmodule // sqf_fault_status

//--- logic/sqf_map.svh
// register map, field positions and reset values of the fault status block
`ifndef SQF_MAP_SVH
`define SQF_MAP_SVH

// ==========================================
// register offsets on the serial register port
`define SQF_SLEEP_EXIT_ORDER_FAULT_STATUS_OFS 8'h1e
`define SQF_SLEEP_ENTRY_ORDER_FAULT_STATUS_OFS 8'h20
`define SQF_CONTROL_COMM_FAULT_STATUS_OFS 8'h22

// ==========================================
// implemented widths; bits above read as zero
`define SQF_SEQ_BITS 6
`define SQF_CTL_BITS 5
`define SQF_DATA_BITS 8

// ==========================================
// control register field positions
`define SQF_CTL_PEC_BIT 0
`define SQF_CTL_SYNC_PIN_BIT 1
`define SQF_CTL_THERMAL_BIT 2
`define SQF_CTL_IRQ_PIN_BIT 3
`define SQF_CTL_REG_CHECK_BIT 4

// ==========================================
// reset values
`define SQF_SEQ_RESET 6'h00
`define SQF_CTL_RESET 5'h00
`define SQF_RDATA_RESET 8'h00

`endif

//--- logic/sqf_pkg.sv
// types shared by the fault status block
package sqf_pkg;

  // ==========================================
  // sequence tracker states, gray along idle -> wait -> idle
  typedef enum logic [1:0] {
    SQF_IDLE = 2'h0,
    SQF_EXIT_WAIT = 2'h1,
    SQF_ENTRY_WAIT = 2'h2
  } sqf_seq_state_t;

endpackage

//--- logic/sqf_sticky.sv
// row of sticky write-1-to-clear status bits
`timescale 1ns/1ps

module sqf_sticky #(
  parameter int W = 6
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [W-1:0] set,
  input wire logic [W-1:0] clr,
  input wire logic [W-1:0] hold,
  output logic [W-1:0] q
);

  logic [W-1:0] next_q; // next status value

  // ==========================================
  // next state
  // clear is blocked where hold is high; set always wins over clear
  always_comb begin
    next_q = (q & ~(clr & ~hold)) | set;
  end

  // ==========================================
  // state register
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

endmodule // sqf_sticky

//--- verification/sqf_fault_status_chk.sv
// port assertions for the fault status block
`timescale 1ns/1ps
module sqf_fault_status_chk (
  input wire logic CLK,
  input wire logic NRST,
  input wire logic [7:0] REG_ADDR,
  input wire logic REG_RD,
  input wire logic [7:0] REG_RDATA,
  input wire logic REG_CHECK_ENABLE,
  input wire logic REG_CHECK_DONE,
  input wire logic REG_CHECK_BAD,
  input wire logic INTERRUPT_OUT_PIN_DRIVE_LOW,
  input wire logic INTERRUPT_OUT_PIN_LEVEL,
  input wire logic THERMAL_SHUTDOWN_ENABLE,
  input wire logic THERMAL_OVERTEMP,
  input wire logic PEC_ENABLE,
  input wire logic REQUIRE_PACKET_CHECK,
  input wire logic XFER_DONE,
  input wire logic XFER_IS_WRITE,
  input wire logic XFER_HAD_PEC,
  input wire logic FAULT_PENDING
);
  // ==========================================
  // one domain, so one clock and one disable
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!NRST);
  // decoded read strobes
  logic rd_ctl, rd_seq;
  assign rd_ctl = REG_RD && REG_ADDR == 8'h22;
  assign rd_seq = REG_RD && (REG_ADDR == 8'h1e || REG_ADDR == 8'h20);
  // ==========================================
  // reserved and unmapped reads
  seq_rsvd_a:
    assert property (rd_seq |=> REG_RDATA[7:6] == 2'h0) else $error("seq reserved bits set");
  ctl_rsvd_a:
    assert property (rd_ctl |=> REG_RDATA[7:5] == 3'h0) else $error("ctl reserved bits set");
  unmapped_zero_a:
    assert property (REG_RD && !rd_ctl && !rd_seq |=> REG_RDATA == 8'h00)
      else $error("unmapped read not zero");
  // ==========================================
  // fault setting, bounded to the synchroniser depth
  reg_check_set_a:
    assert property (REG_CHECK_DONE && REG_CHECK_BAD && REG_CHECK_ENABLE ##1 rd_ctl
      |=> REG_RDATA[4]) else $error("register check fault not seen");
  pending_follow_a:
    assert property (REG_CHECK_DONE && REG_CHECK_BAD && REG_CHECK_ENABLE |=> ##1 FAULT_PENDING)
      else $error("pending flag late");
  pec_missing_a:
    assert property (XFER_DONE && PEC_ENABLE && REQUIRE_PACKET_CHECK && XFER_IS_WRITE
      && !XFER_HAD_PEC ##1 rd_ctl && PEC_ENABLE |=> REG_RDATA[0])
      else $error("missing check byte not flagged");
  pec_off_a:
    assert property (!$past(PEC_ENABLE) && !PEC_ENABLE && rd_ctl |=> !REG_RDATA[0])
      else $error("check fault while disabled");
  thermal_latch_a:
    assert property ((THERMAL_SHUTDOWN_ENABLE && THERMAL_OVERTEMP)[*6] ##0 rd_ctl
      |=> REG_RDATA[2]) else $error("thermal fault not latched");
  irq_fault_a:
    assert property ((INTERRUPT_OUT_PIN_DRIVE_LOW && INTERRUPT_OUT_PIN_LEVEL)[*6] ##0 rd_ctl
      |=> REG_RDATA[3]) else $error("interrupt pin fault not seen");
endmodule // sqf_fault_status_chk

bind sqf_fault_status sqf_fault_status_chk u_sqf_fault_status_chk (
  .CLK, .NRST, .REG_ADDR, .REG_RD, .REG_RDATA, .REG_CHECK_ENABLE, .REG_CHECK_DONE,
  .REG_CHECK_BAD, .INTERRUPT_OUT_PIN_DRIVE_LOW, .INTERRUPT_OUT_PIN_LEVEL,
  .THERMAL_SHUTDOWN_ENABLE, .THERMAL_OVERTEMP, .PEC_ENABLE, .REQUIRE_PACKET_CHECK,
  .XFER_DONE, .XFER_IS_WRITE, .XFER_HAD_PEC, .FAULT_PENDING
);

//--- verification/sqf_host.sv
// host processor model on the register port
`timescale 1ns/1ps
module sqf_host (
  input wire logic CLK,
  output logic [7:0] REG_ADDR,
  output logic REG_WR,
  output logic [7:0] REG_WDATA,
  output logic REG_RD
);
  // ==========================================
  // expected read data, oldest first
  logic [7:0] exp_q[$];
  initial begin
    {REG_ADDR, REG_WR, REG_WDATA, REG_RD} = 18'h00000;
  end
  // one write; called just after an edge, ends after an idle edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    REG_ADDR <= a;
    REG_WDATA <= d;
    REG_WR <= 1'b1;
    @(posedge CLK);
    REG_WR <= 1'b0;
    // released lines never keep the last value
    REG_WDATA <= ~d;
    REG_ADDR <= ~a;
    @(posedge CLK);
  endtask
  // one read, noting what should come back
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    REG_ADDR <= a;
    REG_RD <= 1'b1;
    @(posedge CLK);
    REG_RD <= 1'b0;
    REG_ADDR <= ~a;
    @(posedge CLK);
  endtask
endmodule // sqf_host

//--- verification/sqf_fault_status_bench.sv
// self-checking bench for the fault status block
`timescale 1ns/1ps
module sqf_fault_status_bench;
  // ==========================================
  // port-named signals so the instances hook up by name
  logic CLK, NRST, REG_WR, REG_RD, ACTIVE_SLEEP_CONTROL, SEQ_RECORD_DONE, REG_CHECK_ENABLE;
  logic REG_CHECK_DONE, REG_CHECK_BAD, INTERRUPT_OUT_PIN_DRIVE_LOW, INTERRUPT_OUT_PIN_LEVEL;
  logic THERMAL_SHUTDOWN_ENABLE, THERMAL_OVERTEMP, SYNC_CHECK_ENABLE, SYNC_PIN_DRIVE_LOW;
  logic SYNC_PIN_LEVEL, PEC_ENABLE, REQUIRE_PACKET_CHECK, XFER_DONE, XFER_IS_WRITE;
  logic XFER_HAD_PEC, XFER_PEC_BAD, FAULT_PENDING, rd_q;
  logic [7:0] REG_ADDR, REG_WDATA, REG_RDATA;
  logic [23:0] SLEEP_EXIT_RECORDED_COUNT, SLEEP_EXIT_EXPECTED_COUNT;
  logic [23:0] SLEEP_ENTRY_RECORDED_COUNT, SLEEP_ENTRY_EXPECTED_COUNT;
  logic [5:0] SLEEP_EXIT_FAULT_ENABLE, SLEEP_ENTRY_FAULT_ENABLE;
  logic [31:0] rnd = 32'h98282b6d;
  int err_total = 0;
  int checked = 0;
  sqf_fault_status u_sqf_fault_status (.*);
  sqf_host u_sqf_host (.*);
  initial begin
    CLK = 1'b0;
    forever #2.5 CLK = ~CLK;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] want);
    checked++;
    if (seen !== want) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", what, want, seen);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // ==========================================
  // monitor: read data lands one edge after the strobe
  always @(posedge CLK) begin
    if (rd_q === 1'b1) begin
      check("read data", REG_RDATA, u_sqf_host.exp_q.pop_front());
    end
    rd_q <= REG_RD;
  end
  // fault enables and live pin conditions together
  task automatic cond(input logic en, input logic lvl);
    {REG_CHECK_ENABLE, THERMAL_SHUTDOWN_ENABLE, SYNC_CHECK_ENABLE, PEC_ENABLE} <= {4{en}};
    {INTERRUPT_OUT_PIN_LEVEL, SYNC_PIN_LEVEL, THERMAL_OVERTEMP} <= {3{lvl}};
  endtask
  // one register check and one write transaction ending together
  task automatic pulse(input logic bad, input logic had);
    {REG_CHECK_BAD, XFER_PEC_BAD, XFER_HAD_PEC, XFER_IS_WRITE} <= {bad, bad, had, 1'b1};
    {REG_CHECK_DONE, XFER_DONE} <= 2'h3;
    @(posedge CLK);
    {REG_CHECK_DONE, XFER_DONE} <= 2'h0;
  endtask
  // watchdog, far beyond the under two hundred cycles needed
  initial begin
    #20000;
    err_total++;
    tally_and_finish();
  end
  initial begin
    logic [23:0] d;
    logic [5:0] m;
    logic [7:0] a;
    {NRST, ACTIVE_SLEEP_CONTROL, SEQ_RECORD_DONE, REG_CHECK_ENABLE, REG_CHECK_DONE} = 5'h00;
    {REG_CHECK_BAD, INTERRUPT_OUT_PIN_DRIVE_LOW, INTERRUPT_OUT_PIN_LEVEL} = 3'h0;
    {THERMAL_SHUTDOWN_ENABLE, THERMAL_OVERTEMP, SYNC_CHECK_ENABLE, SYNC_PIN_DRIVE_LOW} = 4'h0;
    {SYNC_PIN_LEVEL, PEC_ENABLE, REQUIRE_PACKET_CHECK, XFER_DONE, XFER_IS_WRITE} = 5'h00;
    {XFER_HAD_PEC, XFER_PEC_BAD, SLEEP_EXIT_FAULT_ENABLE, SLEEP_ENTRY_FAULT_ENABLE} = 14'h0000;
    {SLEEP_EXIT_RECORDED_COUNT, SLEEP_EXIT_EXPECTED_COUNT} = 48'h000000000000;
    {SLEEP_ENTRY_RECORDED_COUNT, SLEEP_ENTRY_EXPECTED_COUNT} = 48'h000000000000;
    repeat (16) @(posedge CLK);
    NRST <= 1'b1;
    @(posedge CLK);
    // ==========================================
    // sleep exit on even passes, entry on odd, random mismatches and enables
    for (int k = 0; k < 4; k++) begin
      rnd = lfsr(rnd);
      m = rnd[5:0];
      for (int i = 0; i < 6; i++) begin
        d[i*4+:4] = {3'h0, m[i]};
      end
      {SLEEP_EXIT_EXPECTED_COUNT, SLEEP_ENTRY_EXPECTED_COUNT} <= {2{rnd[31:8]}};
      {SLEEP_EXIT_RECORDED_COUNT, SLEEP_ENTRY_RECORDED_COUNT} <= {2{rnd[31:8] ^ d}};
      {SLEEP_EXIT_FAULT_ENABLE, SLEEP_ENTRY_FAULT_ENABLE} <= {2{rnd[13:8]}};
      ACTIVE_SLEEP_CONTROL <= ~k[0];
      m = m & rnd[13:8];
      a = k[0] ? 8'h20 : 8'h1e;
      // recorder finishes well after the synchronised edge
      repeat (5) @(posedge CLK);
      SEQ_RECORD_DONE <= 1'b1;
      @(posedge CLK);
      SEQ_RECORD_DONE <= 1'b0;
      u_sqf_host.rd(a, {2'h0, m});
      u_sqf_host.rd(a ^ 8'h3e, 8'h00);
      check("pending", {7'h00, FAULT_PENDING}, {7'h00, |m});
      u_sqf_host.wr(a, 8'h00);
      u_sqf_host.rd(a, {2'h0, m});
      u_sqf_host.wr(a, rnd[23:16]);
      u_sqf_host.rd(a, {2'h0, m & ~rnd[21:16]});
      u_sqf_host.wr(a, 8'hff);
      u_sqf_host.rd(a, 8'h00);
    end
    // a done while idle is dropped; a flip before done re-arms entry
    SEQ_RECORD_DONE <= 1'b1;
    @(posedge CLK);
    SEQ_RECORD_DONE <= 1'b0;
    ACTIVE_SLEEP_CONTROL <= 1'b1;
    repeat (4) @(posedge CLK);
    ACTIVE_SLEEP_CONTROL <= 1'b0;
    repeat (5) @(posedge CLK);
    SEQ_RECORD_DONE <= 1'b1;
    @(posedge CLK);
    SEQ_RECORD_DONE <= 1'b0;
    // same counts as the last pass, so the same mismatch sets again
    u_sqf_host.rd(8'h1e, 8'h00);
    u_sqf_host.rd(8'h20, {2'h0, m});
    // ==========================================
    // control faults: all enabled, then clears with conditions live and gone
    {INTERRUPT_OUT_PIN_DRIVE_LOW, SYNC_PIN_DRIVE_LOW} <= 2'h3;
    cond(1'b1, 1'b1);
    repeat (6) @(posedge CLK);
    pulse(1'b1, 1'b1);
    u_sqf_host.rd(8'h22, 8'h1f);
    u_sqf_host.wr(8'h22, 8'hff);
    u_sqf_host.rd(8'h22, 8'h0e);
    cond(1'b1, 1'b0);
    repeat (6) @(posedge CLK);
    u_sqf_host.rd(8'h22, 8'h0e);
    u_sqf_host.wr(8'h22, 8'hff);
    u_sqf_host.rd(8'h22, 8'h00);
    // enables off: only the pin fault without an enable may set
    cond(1'b0, 1'b1);
    repeat (6) @(posedge CLK);
    pulse(1'b1, 1'b1);
    u_sqf_host.rd(8'h22, 8'h08);
    cond(1'b0, 1'b0);
    repeat (6) @(posedge CLK);
    u_sqf_host.wr(8'h22, 8'hff);
    // write arriving without its check byte
    cond(1'b1, 1'b0);
    REQUIRE_PACKET_CHECK <= 1'b1;
    pulse(1'b0, 1'b0);
    u_sqf_host.rd(8'h22, 8'h01);
    u_sqf_host.wr(8'h22, 8'h01);
    u_sqf_host.rd(8'h22, 8'h00);
    u_sqf_host.rd(8'h81, 8'h00);
    @(posedge CLK);
    tally_and_finish();
  end
endmodule // sqf_fault_status_bench
